// >>> rtl/pie_pkg.sv
`default_nettype none

package pie_pkg;

	// Register byte offsets
	localparam logic [7:0] REG_RPC = 8'h00;
	localparam logic [7:0] REG_SSW = 8'h04;
	localparam logic [7:0] REG_MSW = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam logic [7:0] REG_LINK = 8'h10;
	localparam logic [7:0] REG_CNT = 8'h14;

	// machine_state_word bit indices (vector index, LSB is bit 0)
	localparam int unsigned BIT_EXT_GATE = 15;
	localparam int unsigned BIT_USER = 14;
	localparam int unsigned BIT_FPU = 13;
	localparam int unsigned BIT_HWF = 12;
	localparam int unsigned BIT_FTRAP = 11;
	localparam int unsigned BIT_BYTECHK = 7;
	localparam int unsigned BIT_VBASE = 6;
	localparam int unsigned BIT_IXLATE = 5;
	localparam int unsigned BIT_DXLATE = 4;

	// Reset values and masks
	localparam logic [31:0] MSW_RESET = 32'h00001000;
	localparam logic [31:0] SSW_RESET = 32'h00000000;
	localparam logic [31:0] RPC_RESET = 32'h00000000;
	localparam logic [31:0] MSW_WMASK = 32'h0000f8f0;
	localparam logic [31:0] CLR_NORMAL = 32'h0000e8b0;
	localparam logic [31:0] CLR_MCHK = 32'h0000f8b0;
	localparam logic [31:0] CLR_SYSCALL = 32'h0000c800;

	// Status register fields
	localparam int unsigned STAT_HALT_BIT = 0;
	localparam int unsigned STAT_KIND_LSB = 4;

	// Vector layout
	localparam logic [31:0] VEC_BASE_LOW = 32'h00000000;
	localparam logic [31:0] VEC_BASE_HIGH = 32'hfff00000;
	localparam logic [31:0] VEC_RESET = 32'h00000100;
	localparam logic [31:0] VEC_MCHK = 32'h00000200;
	localparam logic [31:0] VEC_DSTOR = 32'h00000300;
	localparam logic [31:0] VEC_ISTOR = 32'h00000400;
	localparam logic [31:0] VEC_EXT = 32'h00000500;
	localparam logic [31:0] VEC_ALIGN = 32'h00000600;
	localparam logic [31:0] VEC_PROG = 32'h00000700;
	localparam logic [31:0] VEC_FPUNAV = 32'h00000800;
	localparam logic [31:0] VEC_TRACE = 32'h00000900;
	localparam logic [31:0] VEC_FPIMP = 32'h00000a00;
	localparam logic [31:0] VEC_SYSCALL = 32'h00001000;
	localparam int unsigned SYSCALL_SHIFT = 5;

	typedef enum logic [3:0] {
		IRQ_RESET = 4'h0,
		IRQ_MCHK = 4'h1,
		IRQ_DSTOR = 4'h2,
		IRQ_ISTOR = 4'h3,
		IRQ_EXT = 4'h4,
		IRQ_ALIGN = 4'h5,
		IRQ_PROG = 4'h6,
		IRQ_FPUNAV = 4'h7,
		IRQ_TRACE = 4'h8,
		IRQ_FPIMP = 4'h9,
		IRQ_SYSCALL = 4'ha
	} pie_irq_e;

	typedef struct packed {
		logic valid;
		pie_irq_e kind;
		logic [15:0] cause;
		logic [31:0] cur_pc;
		logic [31:0] next_pc;
		logic [31:0] beyond_pc;
		logic cur_faults;
		logic [6:0] entry;
	} pie_req_s;

	typedef struct packed {
		logic valid;
		logic [31:0] target;
		logic [31:0] msw;
	} pie_redir_s;

endpackage

`default_nettype wire

// >>> rtl/pie_top.sv
// Summary of operation
// [RULE_01] Non-call interrupts save current/next address, low two bits zero, in return_pc_save.
// [RULE_02] Non-call interrupts load cause bits into upper half of saved_status_word; reset and machine check load zero instead.
// [RULE_03] Non-call interrupts copy low state half into saved_status_word before changing it.
// [RULE_04] Non-call interrupts clear seven state bits; keep base; machine check clears fault trap.
// [RULE_05] Fetch resumes with new state at selected base plus type offset.
// [RULE_06] Offsets: reset 0x100, machine check 0x200, data storage 0x300.
// [RULE_07] Offsets: instruction storage 0x400, external 0x500, alignment 0x600.
// [RULE_08] Offsets: float unavailable 0x800, trace 0x900.
// [RULE_09] Offsets: program 0x700, float imprecise 0xA00.
// [RULE_10] Offsets 0xB00 to 0xFFF at both bases are never used as vectors.
// [RULE_11] System call saves return address to link, status to count register.
// [RULE_12] System call enters one of 128 points, 0x20 apart, from 0x1000.
// [RULE_13] System call clears only gate, user and float trap bits.
// [RULE_14] Non-call interrupts switch off both translation bits.
// [RULE_15] All interrupts precise except float imprecise, machine check, reset.
// [RULE_16] Program, alignment, data storage save faulting instruction address.
// [RULE_17] Float imprecise saves an address beyond the faulting instruction.
// [RULE_18] External and instruction storage save next instruction address.
// [RULE_19] Reset and machine check save current address if it faults, else next.
// [RULE_20] System call puts return address in link; return_pc_save unchanged.
// [RULE_21] Older instructions completed, none at or after saved address executed.
// [RULE_22] Data storage or alignment suppresses load target and update base writeback.
// [RULE_23] Machine check with fault trap off enters checkstop instead.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none

module pie_top
	import pie_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire pie_req_s req,
	output logic irq_taken,
	output pie_redir_s redir,
	output logic link_we,
	output logic [31:0] link_data,
	output logic count_we,
	output logic [31:0] count_data,
	output logic wb_kill,
	output logic checkstop,
	output logic [31:0] machine_state
);

	////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic [31:0] vec_off(input pie_irq_e k, input logic [6:0] e);
		logic [31:0] o;
		o = VEC_RESET;
		unique case (k)
			IRQ_RESET: o = VEC_RESET; // RULE_06
			IRQ_MCHK: o = VEC_MCHK; // RULE_06
			IRQ_DSTOR: o = VEC_DSTOR; // RULE_06
			IRQ_ISTOR: o = VEC_ISTOR; // RULE_07
			IRQ_EXT: o = VEC_EXT; // RULE_07
			IRQ_ALIGN: o = VEC_ALIGN; // RULE_07
			IRQ_PROG: o = VEC_PROG; // RULE_09
			IRQ_FPUNAV: o = VEC_FPUNAV; // RULE_08
			IRQ_TRACE: o = VEC_TRACE; // RULE_08
			IRQ_FPIMP: o = VEC_FPIMP; // RULE_09
			IRQ_SYSCALL: o = VEC_SYSCALL + {20'h00000, e, 5'h00}; // RULE_12
			default: o = VEC_RESET;
		endcase
		return o;
	endfunction

	function automatic logic [31:0] pick_ret(input pie_req_s r);
		logic [31:0] a;
		a = r.next_pc;
		unique case (r.kind)
			IRQ_PROG, IRQ_ALIGN, IRQ_DSTOR, IRQ_FPUNAV: a = r.cur_pc; // RULE_16
			IRQ_FPIMP: a = r.beyond_pc; // RULE_17 RULE_15
			IRQ_EXT, IRQ_ISTOR, IRQ_TRACE: a = r.next_pc; // RULE_18
			IRQ_RESET, IRQ_MCHK: a = r.cur_faults ? r.cur_pc : r.next_pc; // RULE_19 RULE_15
			IRQ_SYSCALL: a = r.next_pc; // RULE_20
			default: a = r.next_pc;
		endcase
		return {a[31:2], 2'b00};
	endfunction

	function automatic logic is_sys(input pie_irq_e k);
		return k == IRQ_SYSCALL;
	endfunction

	////////////////////////////////////////////////////////////////
	// State

	logic [31:0] rpc_q;
	logic [31:0] ssw_q;
	logic [31:0] msw_q;
	logic [31:0] link_q;
	logic [31:0] cnt_q;
	logic halt_q;
	pie_irq_e last_kind_q;
	logic pready_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic taken_q;
	pie_redir_s redir_q;
	logic link_we_q;
	logic count_we_q;
	logic wb_kill_q;

	////////////////////////////////////////////////////////////////
	// Interrupt acceptance

	logic active;
	logic fault_off;
	logic take;
	logic stop;
	logic sys;
	logic [31:0] ret_addr;
	logic [31:0] base;
	logic [31:0] clr_mask;
	logic [31:0] msw_new;
	logic [15:0] cause_new;

	always_comb
	begin
		active = clk_en & req.valid & ~halt_q;
		fault_off = ~msw_q[BIT_HWF];
		stop = active & (req.kind == IRQ_MCHK) & fault_off; // RULE_23
		take = active & ~stop;
		sys = is_sys(req.kind);
		ret_addr = pick_ret(req); // RULE_01
		base = msw_q[BIT_VBASE] ? VEC_BASE_HIGH : VEC_BASE_LOW;
		if (sys)
			clr_mask = CLR_SYSCALL; // RULE_13
		else if (req.kind == IRQ_MCHK)
			clr_mask = CLR_MCHK; // RULE_04
		else
			clr_mask = CLR_NORMAL; // RULE_04 RULE_14
		msw_new = msw_q & ~clr_mask;
		if (req.kind == IRQ_RESET || req.kind == IRQ_MCHK)
			cause_new = 16'h0000;
		else
			cause_new = req.cause; // RULE_02
	end

	////////////////////////////////////////////////////////////////
	// APB slave

	logic rd_setup;
	logic wr_en;
	logic mapped;
	logic [31:0] rd_mux;

	always_comb
	begin
		rd_setup = psel & ~penable;
		wr_en = psel & penable & pwrite & pready_q & ~pslverr_q;
		mapped = 1'b1;
		rd_mux = 32'h00000000;
		unique case (paddr)
			REG_RPC: rd_mux = rpc_q;
			REG_SSW: rd_mux = ssw_q;
			REG_MSW: rd_mux = msw_q;
			REG_STAT:
			begin
				rd_mux[STAT_HALT_BIT] = halt_q;
				rd_mux[STAT_KIND_LSB +: 4] = last_kind_q;
			end
			REG_LINK: rd_mux = link_q;
			REG_CNT: rd_mux = cnt_q;
			default: mapped = 1'b0;
		endcase
	end

	// One wait-free access phase; error on unmapped address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
		end
		else if (clk_en)
		begin
			pready_q <= rd_setup;
			if (rd_setup)
			begin
				prdata_q <= pwrite ? 32'h00000000 : rd_mux;
				pslverr_q <= ~mapped;
			end
			else
			begin
				pslverr_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Save registers; interrupt beats a software write

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rpc_q <= RPC_RESET;
		else if (take && !sys)
			rpc_q <= ret_addr; // RULE_01 RULE_21
		else if (clk_en && wr_en && paddr == REG_RPC)
			rpc_q <= pwdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ssw_q <= SSW_RESET;
		else if (take && !sys)
			ssw_q <= {cause_new, msw_q[15:0]}; // RULE_02 RULE_03
		else if (clk_en && wr_en && paddr == REG_SSW)
			ssw_q <= pwdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			msw_q <= MSW_RESET;
		else if (take)
			msw_q <= msw_new; // RULE_04 RULE_13 RULE_14
		else if (clk_en && wr_en && paddr == REG_MSW)
			msw_q <= pwdata & MSW_WMASK;
	end

	// Link and count copies for system calls
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link_q <= 32'h00000000;
			cnt_q <= 32'h00000000;
			link_we_q <= 1'b0;
			count_we_q <= 1'b0;
		end
		else if (clk_en)
		begin
			link_we_q <= take & sys;
			count_we_q <= take & sys;
			if (take && sys)
			begin
				link_q <= ret_addr; // RULE_11 RULE_20
				cnt_q <= msw_q; // RULE_11
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Redirect, writeback kill, checkstop

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			taken_q <= 1'b0;
			redir_q <= '0;
			wb_kill_q <= 1'b0;
		end
		else if (clk_en)
		begin
			taken_q <= take;
			redir_q.valid <= take;
			wb_kill_q <= take & (req.kind == IRQ_DSTOR || req.kind == IRQ_ALIGN); // RULE_22
			if (take)
			begin
				redir_q.target <= base + vec_off(req.kind, req.entry); // RULE_05 RULE_10
				redir_q.msw <= msw_new; // RULE_05
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			halt_q <= 1'b0;
			last_kind_q <= IRQ_RESET;
		end
		else if (clk_en)
		begin
			if (stop)
				halt_q <= 1'b1; // RULE_23
			if (take)
				last_kind_q <= req.kind;
		end
	end

	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign irq_taken = taken_q;
	assign redir = redir_q;
	assign link_we = link_we_q;
	assign link_data = link_q;
	assign count_we = count_we_q;
	assign count_data = cnt_q;
	assign wb_kill = wb_kill_q;
	assign checkstop = halt_q;
	assign machine_state = msw_q;

	////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	rpc_low_zero_a: assert property ( // RULE_01
		(take && !sys) |=> (rpc_q[1:0] == 2'b00 && taken_q))
		else $error("return_pc_save low bits not zero");

	cause_load_a: assert property ( // RULE_02
		(take && !sys && req.kind != IRQ_RESET && req.kind != IRQ_MCHK)
		|=> ssw_q[31:16] == $past(req.cause))
		else $error("cause bits not saved");

	state_copy_a: assert property ( // RULE_03
		(take && !sys) |=> ssw_q[15:0] == $past(msw_q[15:0]))
		else $error("state half not copied");

	clear_bits_a: assert property ( // RULE_04
		(take && !sys) |=> ((msw_q & CLR_NORMAL) == 32'h00000000
		&& msw_q[BIT_VBASE] == $past(msw_q[BIT_VBASE])))
		else $error("state bits not cleared");

	mchk_trap_a: assert property ( // RULE_04
		(take && req.kind == IRQ_MCHK) |=> !msw_q[BIT_HWF])
		else $error("fault trap kept on machine check");

	vector_a: assert property ( // RULE_05
		(take && !sys) |=> redir.valid
		&& redir.target == (($past(msw_q[BIT_VBASE]) ? VEC_BASE_HIGH : VEC_BASE_LOW)
		+ vec_off($past(req.kind), 7'h00)) && redir.msw == msw_q)
		else $error("wrong vector target");

	reserved_gap_a: assert property ( // RULE_10
		redir.valid |-> (redir.target[11:8] < 4'hb || redir.target[12]))
		else $error("vector lands in reserved range");

	syscall_link_a: assert property ( // RULE_20
		(take && sys) |=> (link_we && count_we && rpc_q == $past(rpc_q)
		&& link_data == $past(ret_addr)))
		else $error("system call save wrong");

	syscall_bits_a: assert property ( // RULE_13
		(take && sys) |=> msw_q == ($past(msw_q) & ~CLR_SYSCALL))
		else $error("system call state wrong");

	syscall_entry_a: assert property ( // RULE_12
		(take && sys) |=> (redir.target[4:0] == 5'h00
		&& redir.target[19:12] == 8'h01))
		else $error("system call entry wrong");

	wb_kill_a: assert property ( // RULE_22
		(take && (req.kind == IRQ_DSTOR || req.kind == IRQ_ALIGN)) |=> wb_kill)
		else $error("writeback not suppressed");

	checkstop_a: assert property ( // RULE_23
		stop |=> (checkstop && !irq_taken) ##1 checkstop)
		else $error("checkstop not entered");

	cover_normal_c: cover property (take && req.kind == IRQ_EXT ##1 redir.valid);
	cover_sys_c: cover property (take && sys ##1 link_we);
	cover_stop_c: cover property (stop ##1 checkstop);
	cover_mchk_c: cover property (take && req.kind == IRQ_MCHK && req.cur_faults);

endmodule

`default_nettype wire

// >>> dv/pie_pipe_model.sv
`timescale 1ns/100ps
`default_nettype none

module pie_pipe_model
	import pie_pkg::*;
(
	input wire logic pclk,
	output var pie_req_s req
);
	pie_req_s idle;

	initial req = '0;

	////////////////////////////////////////////////////////////////
	// One-cycle request; fields turn over once valid drops
	task automatic fire(input pie_irq_e k, input logic [15:0] c, input logic [31:0] cp, input logic cf,
		input logic [6:0] e);
		@(posedge pclk);
		req <= '{valid: 1'b1, kind: k, cause: c, cur_pc: cp, next_pc: cp + 32'h4, beyond_pc: cp + 32'hc,
			cur_faults: cf, entry: e};
		@(posedge pclk);
		idle = ~req;
		idle.valid = 1'b0;
		req <= idle;
	endtask
endmodule

`default_nettype wire

// >>> dv/processor_interrupt_entry_tb.sv
`timescale 1ns/100ps
`default_nettype none

module processor_interrupt_entry_tb
	import pie_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	pie_req_s req;
	pie_redir_s redir;
	logic irq_taken;
	logic link_we;
	logic count_we;
	logic wb_kill;
	logic checkstop;
	logic [31:0] link_data;
	logic [31:0] count_data;
	logic [31:0] machine_state;
	int errors = 0;
	int total_checks = 0;
	logic [31:0] rd;
	logic err;
	logic [31:0] old;
	logic [31:0] cp;
	logic [31:0] exp_pc;
	logic [31:0] exp_msw;
	logic [15:0] c;
	pie_irq_e k;

	always #5 pclk = ~pclk;

	pie_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.req(req), .irq_taken(irq_taken), .redir(redir), .link_we(link_we), .link_data(link_data),
		.count_we(count_we), .count_data(count_data), .wb_kill(wb_kill), .checkstop(checkstop),
		.machine_state(machine_state));

	pie_pipe_model pipe (.pclk(pclk), .req(req));

	////////////////////////////////////////////////////////////////
	task automatic test_done;
		if (errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_b(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [31:0] pc_of(input pie_irq_e kk, input logic [31:0] p, input logic cf);
		case (kk)
			IRQ_ISTOR, IRQ_EXT, IRQ_TRACE: return p + 32'h4;
			IRQ_FPIMP: return p + 32'hc;
			IRQ_RESET, IRQ_MCHK: return cf ? p : p + 32'h4;
			default: return p;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	initial
	begin
		#100000;
		errors++;
		test_done();
	end

	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk_w(machine_state, MSW_RESET);
		apb(1'b0, REG_RPC, 32'h0);
		chk_w(rd, RPC_RESET);
		apb(1'b0, REG_SSW, 32'h0);
		chk_w(rd, SSW_RESET);
		apb(1'b1, 8'h18, 32'h12345678);
		chk_b(err, 1'b1);
		apb(1'b0, 8'h18, 32'h0);
		chk_w({rd[31:1], err}, 32'h1);
		apb(1'b1, REG_MSW, 32'hffffffff);
		apb(1'b0, REG_MSW, 32'h0);
		chk_w(rd, MSW_WMASK);
		for (int i = 0; i < 10; i++)
		begin
			k = pie_irq_e'(i);
			old = i[0] ? 32'h0000f8f0 : 32'h0000f8b0;
			cp = 32'h40000103 + (32'(i) << 8);
			c = 16'ha5c0 + 16'(i);
			exp_msw = old & ~((k == IRQ_MCHK) ? CLR_MCHK : CLR_NORMAL);
			apb(1'b1, REG_MSW, old);
			pipe.fire(k, c, cp, i[0], 7'h00);
			#1;
			chk_b(irq_taken & redir.valid, 1'b1);
			chk_b(wb_kill, k == IRQ_DSTOR || k == IRQ_ALIGN);
			chk_w(redir.target, (old[BIT_VBASE] ? VEC_BASE_HIGH : VEC_BASE_LOW) + (32'(i + 1) << 8));
			chk_w(machine_state, exp_msw);
			chk_w(redir.msw, exp_msw);
			chk_b(link_we | count_we, 1'b0);
			exp_pc = pc_of(k, cp, i[0]) & ~32'h3;
			apb(1'b0, REG_RPC, 32'h0);
			chk_w(rd, exp_pc);
			apb(1'b0, REG_SSW, 32'h0);
			chk_w(rd, {(k == IRQ_RESET || k == IRQ_MCHK) ? 16'h0000 : c, old[15:0]});
		end
		for (int e = 0; e < 128; e += 127)
		begin
			old = e[0] ? 32'h0000f8b0 : 32'h0000f8f0;
			apb(1'b1, REG_MSW, old);
			pipe.fire(IRQ_SYSCALL, 16'h1234, 32'h00002001, 1'b0, 7'(e));
			#1;
			chk_b(link_we & count_we & irq_taken, 1'b1);
			chk_w(redir.target, (old[BIT_VBASE] ? VEC_BASE_HIGH : VEC_BASE_LOW) + 32'h1000 + (32'(e) << 5));
			chk_w(link_data, 32'h00002004);
			chk_w(count_data, old);
			chk_w(machine_state, old & ~32'h0000c800);
			@(posedge pclk);
			#1;
			chk_b(irq_taken | link_we | count_we, 1'b0);
			apb(1'b0, REG_RPC, 32'h0);
			chk_w(rd, exp_pc);
		end
		clk_en <= 1'b0;
		pipe.fire(IRQ_EXT, 16'h0003, 32'h00002100, 1'b0, 7'h00);
		#1;
		chk_b(irq_taken | redir.valid, 1'b0);
		chk_w(machine_state, 32'h000030b0);
		@(posedge pclk);
		clk_en <= 1'b1;
		apb(1'b1, REG_MSW, 32'h0000e8f0);
		pipe.fire(IRQ_MCHK, 16'h0001, 32'h00003000, 1'b0, 7'h00);
		#1;
		chk_b(irq_taken, 1'b0);
		chk_b(checkstop, 1'b1);
		pipe.fire(IRQ_EXT, 16'h0002, 32'h00003100, 1'b0, 7'h00);
		#1;
		chk_b(irq_taken, 1'b0);
		chk_w(machine_state, 32'h0000e8f0);
		apb(1'b0, REG_STAT, 32'h0);
		chk_b(rd[STAT_HALT_BIT], 1'b1);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk_b(checkstop, 1'b0);
		chk_w(machine_state, MSW_RESET);
		test_done();
	end
endmodule

`default_nettype wire
